//--- pkg/lcc_pkg.sv
// Constants, types and register map of the logic cell control slice.
// Assumes an AHB-Lite bus with 32-bit words and one aligned word per register.
package lcc_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CELL_CONTROL = 8'h00;
	localparam logic [7:0] OFS_OUTPUT_POL = 8'h04;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h0c;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;

	// Field positions of cell_control
	localparam int POS_ENABLE = 7;
	localparam int POS_OUT_STATUS = 5;
	localparam int POS_RISE_IE = 4;
	localparam int POS_FALL_IE = 3;
	localparam int POS_FUNC_LSB = 0;
	// Field position of output_invert in the polarity register
	localparam int POS_OUTPUT_INVERT = 7;
	// Field position of cell_irq_flag in status, clear and enable registers
	localparam int POS_IRQ_FLAG = 0;

	// Reset values
	localparam logic RST_ENABLE = 1'h0;
	localparam logic RST_RISE_IE = 1'h0;
	localparam logic RST_FALL_IE = 1'h0;
	localparam logic [2:0] RST_FUNC = 3'h0;
	localparam logic RST_OUTPUT_INVERT = 1'h0;
	localparam logic RST_IRQ_ENABLE = 1'h0;

	localparam int GATE_COUNT = 4;

	typedef enum logic [2:0] {
		LCC_AND_OR = 3'h0,
		LCC_OR_XOR = 3'h1,
		LCC_AND4 = 3'h2,
		LCC_SR_LATCH = 3'h3,
		LCC_DFF_SR = 3'h4,
		LCC_DFF2_R = 3'h5,
		LCC_JK_R = 3'h6,
		LCC_LATCH_SR = 3'h7
	} lcc_func_t;

	typedef struct packed {
		logic enable;
		logic rise_ie;
		logic fall_ie;
		lcc_func_t func;
	} lcc_ctrl_t;

	// Bus data phase, one-hot
	typedef enum logic [3:0] {
		LCC_BUS_IDLE = 4'h1,
		LCC_BUS_WR = 4'h2,
		LCC_BUS_RD_WAIT = 4'h4,
		LCC_BUS_RD_DONE = 4'h8
	} lcc_bus_t;

endpackage : lcc_pkg

//--- src/lcc_cell.sv
// Logic cell with its control, polarity, interrupt and AHB-Lite register slave.
// Assumes gate inputs arrive asynchronously from pins or other peripherals.
//
// Contract
// - Enable 1: cell active, combines selected inputs by the chosen function.
// - Enable 0: cell disabled, output held at constant zero.
// - Output status bit is read-only, shows cell output after inversion.
// - Rising enable 1: flag set on each low-to-high edge of cell output.
// - Falling enable set: flag set on each high-to-low edge of cell output.
// - Edge enable 0 blocks that direction from setting the flag.
// - Three-bit function select chooses the cell's logic or storage function.
// - Code 100: one-input D flip-flop with set and reset.
// - Unimplemented control bits ignore writes and read zero.
// - Output invert 1 inverts cell output; 0 passes it unchanged.
`timescale 1ns/1ps
`default_nettype none

module lcc_cell (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Cell gate inputs, asynchronous
	input wire logic [3:0] gate_in,
	// Cell output and interrupt
	output logic cell_out,
	output logic irq
);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	lcc_pkg::lcc_ctrl_t ctrl;
	logic output_invert;
	logic cell_irq_flag;
	logic irq_enable;
	lcc_pkg::lcc_bus_t bus_state;
	lcc_pkg::lcc_bus_t next_bus_state;
	logic [7:0] dp_addr;
	logic accept;

	// Gate input synchronisers
	logic [3:0] gate_meta;
	logic [3:0] gate;
	logic g1_prev;

	genvar gi;
	generate
		for (gi = 0; gi < lcc_pkg::GATE_COUNT; gi++) begin : g_sync
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					gate_meta[gi] <= 1'h0;
					gate[gi] <= 1'h0;
				end else begin
					gate_meta[gi] <= gate_in[gi];
					gate[gi] <= gate_meta[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			g1_prev <= 1'h0;
		end else begin
			g1_prev <= gate[0];
		end
	end

	// Bus data phase tracking
	assign accept = hsel && hready && htrans[1];

	always_comb begin
		next_bus_state = lcc_pkg::LCC_BUS_IDLE;
		case (bus_state)
			lcc_pkg::LCC_BUS_RD_WAIT: begin
				next_bus_state = lcc_pkg::LCC_BUS_RD_DONE;
			end
			lcc_pkg::LCC_BUS_IDLE, lcc_pkg::LCC_BUS_WR, lcc_pkg::LCC_BUS_RD_DONE: begin
				if (accept) begin
					next_bus_state = hwrite ? lcc_pkg::LCC_BUS_WR : lcc_pkg::LCC_BUS_RD_WAIT;
				end
			end
			default: begin
				next_bus_state = lcc_pkg::LCC_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_state <= lcc_pkg::LCC_BUS_IDLE;
			dp_addr <= 8'h00;
		end else begin
			bus_state <= next_bus_state;
			if (accept) begin
				dp_addr <= haddr[7:0];
			end
		end
	end

	// One wait state on reads so a read right after a write sees the new value
	assign hreadyout = (bus_state != lcc_pkg::LCC_BUS_RD_WAIT);
	assign hresp = 1'h0;

	logic wr_en;
	assign wr_en = (bus_state == lcc_pkg::LCC_BUS_WR);

	// Control, polarity and interrupt enable registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl.enable <= lcc_pkg::RST_ENABLE;
			ctrl.rise_ie <= lcc_pkg::RST_RISE_IE;
			ctrl.fall_ie <= lcc_pkg::RST_FALL_IE;
			ctrl.func <= lcc_pkg::lcc_func_t'(lcc_pkg::RST_FUNC);
		end else if (wr_en && hit(dp_addr, lcc_pkg::OFS_CELL_CONTROL)) begin
			// Bits 6 and 5 are not stored
			ctrl.enable <= hwdata[lcc_pkg::POS_ENABLE];
			ctrl.rise_ie <= hwdata[lcc_pkg::POS_RISE_IE];
			ctrl.fall_ie <= hwdata[lcc_pkg::POS_FALL_IE];
			ctrl.func <= lcc_pkg::lcc_func_t'(hwdata[lcc_pkg::POS_FUNC_LSB +: 3]);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			output_invert <= lcc_pkg::RST_OUTPUT_INVERT;
			irq_enable <= lcc_pkg::RST_IRQ_ENABLE;
		end else if (wr_en) begin
			if (hit(dp_addr, lcc_pkg::OFS_OUTPUT_POL)) begin
				output_invert <= hwdata[lcc_pkg::POS_OUTPUT_INVERT];
			end
			if (hit(dp_addr, lcc_pkg::OFS_IRQ_ENABLE)) begin
				irq_enable <= hwdata[lcc_pkg::POS_IRQ_FLAG];
			end
		end
	end

	// Cell function
	logic set_in;
	logic rst_in;
	logic clk_rise;
	logic q;
	logic next_q;
	logic raw;
	logic next_cell_out;

	assign clk_rise = gate[0] && !g1_prev;

	always_comb begin
		set_in = gate[3];
		rst_in = gate[2];
		next_q = q;
		raw = q;
		case (ctrl.func)
			lcc_pkg::LCC_AND_OR: begin
				raw = (gate[0] & gate[1]) | (gate[2] & gate[3]);
				next_q = 1'h0;
			end
			lcc_pkg::LCC_OR_XOR: begin
				raw = (gate[0] | gate[1]) ^ (gate[2] | gate[3]);
				next_q = 1'h0;
			end
			lcc_pkg::LCC_AND4: begin
				raw = &gate;
				next_q = 1'h0;
			end
			lcc_pkg::LCC_SR_LATCH: begin
				set_in = gate[0] | gate[1];
				rst_in = gate[2] | gate[3];
				if (rst_in) begin
					next_q = 1'h0;
				end else if (set_in) begin
					next_q = 1'h1;
				end
			end
			lcc_pkg::LCC_DFF_SR: begin
				if (rst_in) begin
					next_q = 1'h0;
				end else if (set_in) begin
					next_q = 1'h1;
				end else if (clk_rise) begin
					next_q = gate[1];
				end
			end
			lcc_pkg::LCC_DFF2_R: begin
				if (rst_in) begin
					next_q = 1'h0;
				end else if (clk_rise) begin
					next_q = gate[1] & gate[3];
				end
			end
			lcc_pkg::LCC_JK_R: begin
				if (rst_in) begin
					next_q = 1'h0;
				end else if (clk_rise) begin
					case ({gate[1], gate[3]})
						2'h1: next_q = 1'h0;
						2'h2: next_q = 1'h1;
						2'h3: next_q = !q;
						default: next_q = q;
					endcase
				end
			end
			lcc_pkg::LCC_LATCH_SR: begin
				if (rst_in) begin
					next_q = 1'h0;
				end else if (set_in) begin
					next_q = 1'h1;
				end else if (gate[0]) begin
					next_q = gate[1];
				end
			end
			default: begin
				next_q = 1'h0;
			end
		endcase
		if (!ctrl.enable) begin
			next_q = 1'h0;
		end
	end

	// Storage element of the sequential functions
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= 1'h0;
		end else begin
			q <= next_q;
		end
	end

	// Polarity applied to an active cell; a disabled cell drives zero
	assign next_cell_out = ctrl.enable ? (raw ^ output_invert) : 1'h0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cell_out <= 1'h0;
		end else begin
			cell_out <= next_cell_out;
		end
	end

	// Edge interrupt flag
	logic out_prev;
	logic flag_set;
	logic flag_clr;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_prev <= 1'h0;
		end else begin
			out_prev <= cell_out;
		end
	end

	assign flag_set = (ctrl.rise_ie && cell_out && !out_prev)
		|| (ctrl.fall_ie && !cell_out && out_prev);
	assign flag_clr = wr_en && hit(dp_addr, lcc_pkg::OFS_IRQ_CLEAR)
		&& hwdata[lcc_pkg::POS_IRQ_FLAG];

	// Set wins over a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cell_irq_flag <= 1'h0;
		end else if (flag_set) begin
			cell_irq_flag <= 1'h1;
		end else if (flag_clr) begin
			cell_irq_flag <= 1'h0;
		end
	end

	assign irq = cell_irq_flag && irq_enable;

	// Read data, loaded in the wait cycle
	logic [31:0] rd_val;

	always_comb begin
		rd_val = 32'h0000_0000;
		if (hit(dp_addr, lcc_pkg::OFS_CELL_CONTROL)) begin
			rd_val[lcc_pkg::POS_ENABLE] = ctrl.enable;
			rd_val[lcc_pkg::POS_OUT_STATUS] = cell_out;
			rd_val[lcc_pkg::POS_RISE_IE] = ctrl.rise_ie;
			rd_val[lcc_pkg::POS_FALL_IE] = ctrl.fall_ie;
			rd_val[lcc_pkg::POS_FUNC_LSB +: 3] = ctrl.func;
		end else if (hit(dp_addr, lcc_pkg::OFS_OUTPUT_POL)) begin
			rd_val[lcc_pkg::POS_OUTPUT_INVERT] = output_invert;
		end else if (hit(dp_addr, lcc_pkg::OFS_IRQ_STATUS)) begin
			rd_val[lcc_pkg::POS_IRQ_FLAG] = cell_irq_flag;
		end else if (hit(dp_addr, lcc_pkg::OFS_IRQ_ENABLE)) begin
			rd_val[lcc_pkg::POS_IRQ_FLAG] = irq_enable;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (bus_state == lcc_pkg::LCC_BUS_RD_WAIT) begin
			hrdata <= rd_val;
		end
	end

endmodule : lcc_cell

`default_nettype wire

//--- testbench/lcc_cell_asserts.sv
// Checker of the logic cell slice, bound to lcc_cell.
// Assumes hready is tied to hreadyout by the bench.
`timescale 1ns/1ps
`default_nettype none
module lcc_cell_asserts (
	// Clock and bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Cell
	input wire logic [3:0] gate_in,
	input wire logic cell_out,
	input wire logic irq
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic take_rd;
	logic take_wr;
	logic [3:0] gate_q;
	logic [3:0] quiet;
	assign take_rd = hsel && hready && htrans[1] && !hwrite;
	assign take_wr = hsel && hready && htrans[1] && hwrite;
	// Cycles with steady gates and no bus traffic
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gate_q <= 4'h0;
			quiet <= 4'h0;
		end else begin
			gate_q <= gate_in;
			if (take_rd || take_wr || gate_in != gate_q)
				quiet <= 4'h0;
			else if (quiet != 4'hf)
				quiet <= quiet + 4'h1;
		end
	end
	sequence rd_answer;
		!hreadyout ##1 hreadyout;
	endsequence
	AST_RD_WAIT: assert property (take_rd |=> rd_answer)
		else $error("read wait not one cycle");
	AST_WR_NOWAIT: assert property (take_wr |=> hreadyout)
		else $error("write data phase stalled");
	AST_WAIT_ONE: assert property (!hreadyout |=> hreadyout)
		else $error("wait longer than one cycle");
	AST_OKAY: assert property (hresp == 1'b0)
		else $error("response not okay");
	AST_RD_HOLD: assert property ($past(hreadyout) |-> $stable(hrdata))
		else $error("read data changed outside read");
	AST_CELL_STEADY: assert property (quiet >= 4'h6 |-> $stable(cell_out))
		else $error("cell output moved with steady inputs");
	AST_IRQ_RISE: assert property ($rose(irq) |->
		$past(cell_out) != $past(cell_out, 2) || $past(take_wr, 2))
		else $error("interrupt rose without cause");
	AST_IRQ_FALL: assert property ($fell(irq) |-> $past(take_wr, 2))
		else $error("interrupt fell without write");
endmodule : lcc_cell_asserts
`default_nettype wire

//--- testbench/lcc_far.sv
// Far side model: pins feeding the cell gates.
// Assumes gate levels change right after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module lcc_far (
	// Clock
	input wire logic hclk,
	// Requested and driven gate levels
	input wire logic [3:0] want,
	output logic [3:0] gate_in
);
	always_ff @(posedge hclk) gate_in <= want;
endmodule : lcc_far
`default_nettype wire

//--- testbench/test_logic_cell_control.sv
// Self-checking bench of lcc_cell over AHB-Lite.
// Assumes lcc_far drives the gates and the checker is bound below.
`timescale 1ns/1ps
`default_nettype none
module test_logic_cell_control;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [3:0] want = 4'h0;
	logic [31:0] hrdata;
	logic [31:0] r;
	logic [3:0] gate_in;
	logic hready, hreadyout, hresp, cell_out, irq;
	int fails = 0;
	int total_checks = 0;
	typedef struct packed {
		logic [7:0] ctrl;
		logic pol;
		logic [3:0] gate;
		logic exp;
	} lcc_row_t;
	lcc_row_t rows [32] = '{'{8'h80, 1'h0, 4'h3, 1'h1}, '{8'h80, 1'h0, 4'hc, 1'h1},
		'{8'h80, 1'h0, 4'h5, 1'h0}, '{8'h81, 1'h0, 4'h1, 1'h1}, '{8'h81, 1'h0, 4'h5, 1'h0},
		'{8'h82, 1'h0, 4'hf, 1'h1}, '{8'h82, 1'h0, 4'h7, 1'h0}, '{8'h83, 1'h0, 4'h1, 1'h1},
		'{8'h83, 1'h0, 4'h0, 1'h1}, '{8'h83, 1'h0, 4'h4, 1'h0}, '{8'h84, 1'h0, 4'h4, 1'h0},
		'{8'h84, 1'h0, 4'h2, 1'h0}, '{8'h84, 1'h0, 4'h3, 1'h1}, '{8'h84, 1'h0, 4'h1, 1'h1},
		'{8'h84, 1'h0, 4'h8, 1'h1}, '{8'h84, 1'h0, 4'h4, 1'h0}, '{8'h87, 1'h0, 4'h4, 1'h0},
		'{8'h87, 1'h0, 4'h3, 1'h1}, '{8'h87, 1'h0, 4'h1, 1'h0}, '{8'h87, 1'h0, 4'h2, 1'h0},
		'{8'h87, 1'h0, 4'h8, 1'h1}, '{8'h85, 1'h0, 4'h4, 1'h0}, '{8'h85, 1'h0, 4'hb, 1'h1},
		'{8'h86, 1'h0, 4'h4, 1'h0}, '{8'h86, 1'h0, 4'h3, 1'h1}, '{8'h86, 1'h0, 4'h0, 1'h1},
		'{8'h86, 1'h0, 4'h9, 1'h0}, '{8'h86, 1'h0, 4'h0, 1'h0}, '{8'h86, 1'h0, 4'hb, 1'h1},
		'{8'h82, 1'h1, 4'hf, 1'h0}, '{8'h82, 1'h1, 4'h7, 1'h1},
		'{8'h02, 1'h1, 4'hf, 1'h0}};
	logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};
	assign hready = hreadyout;
	initial forever #10 hclk = ~hclk;
	lcc_cell DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.gate_in(gate_in), .cell_out(cell_out), .irq(irq));
	lcc_far u_far (.hclk(hclk), .want(want), .gate_in(gate_in));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			fails++;
			complete_run();
		end
	endtask : wait_ready
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		r = hrdata;
	endtask : bus
	task automatic settle(input logic [3:0] g);
		want <= g;
		repeat (6) @(posedge hclk);
	endtask : settle
	task automatic complete_run();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		chk(32'({cell_out, irq}), 32'h0);
		foreach (offs[i]) begin
			bus(offs[i], 1'b0, 32'h0);
			chk(r, 32'h0);
		end
		foreach (rows[i]) begin
			bus(lcc_pkg::OFS_CELL_CONTROL, 1'b1, {24'h0, rows[i].ctrl});
			bus(lcc_pkg::OFS_OUTPUT_POL, 1'b1, {24'h0, rows[i].pol, 7'h0});
			settle(rows[i].gate);
			chk(32'(cell_out), 32'(rows[i].exp));
			bus(lcc_pkg::OFS_CELL_CONTROL, 1'b0, 32'h0);
			chk(r, {24'h0, rows[i].ctrl | {2'h0, rows[i].exp, 5'h0}});
		end
		settle(4'h0);
		bus(lcc_pkg::OFS_OUTPUT_POL, 1'b1, 32'h0);
		bus(lcc_pkg::OFS_IRQ_ENABLE, 1'b1, 32'h1);
		bus(lcc_pkg::OFS_CELL_CONTROL, 1'b1, 32'h92);
		bus(lcc_pkg::OFS_IRQ_CLEAR, 1'b1, 32'h1);
		settle(4'hf);
		chk(32'(irq), 32'h1);
		bus(lcc_pkg::OFS_IRQ_CLEAR, 1'b1, 32'h1);
		settle(4'h0);
		chk(32'(irq), 32'h0);
		bus(lcc_pkg::OFS_CELL_CONTROL, 1'b1, 32'h8a);
		settle(4'hf);
		chk(32'(irq), 32'h0);
		settle(4'h0);
		chk(32'(irq), 32'h1);
		bus(lcc_pkg::OFS_IRQ_ENABLE, 1'b1, 32'h0);
		@(posedge hclk);
		chk(32'(irq), 32'h0);
		bus(lcc_pkg::OFS_IRQ_STATUS, 1'b0, 32'h0);
		chk(r, 32'h1);
		bus(lcc_pkg::OFS_IRQ_CLEAR, 1'b1, 32'h1);
		bus(lcc_pkg::OFS_IRQ_STATUS, 1'b0, 32'h0);
		chk(r, 32'h0);
		bus(lcc_pkg::OFS_CELL_CONTROL, 1'b1, 32'hffffffff);
		bus(lcc_pkg::OFS_CELL_CONTROL, 1'b0, 32'h0);
		chk(r & 32'hffffffdf, 32'h9f);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		chk(32'({cell_out, irq}), 32'h0);
		bus(lcc_pkg::OFS_CELL_CONTROL, 1'b0, 32'h0);
		chk(r, 32'h0);
		complete_run();
	end
endmodule : test_logic_cell_control
bind lcc_cell lcc_cell_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .gate_in(gate_in), .cell_out(cell_out), .irq(irq));
`default_nettype wire
